// *** rtl/mcsel_top.sv ***
// Modulator carrier selection, conditioning and output switching.
// Assumes carrier sources and modulation data may be asynchronous pins.
// What this block does
// - High carrier disable bit set turns off high carrier pin drive.
// - High carrier invert bit set inverts the selected high carrier.
// - High sync bit waits for high carrier falling edge before switching.
// - High source code: ground, pin one, pin two, refclk, PWM 1-7.
// - Low carrier disable bit set turns off low carrier pin drive.
// - Low carrier invert bit set inverts the selected low carrier.
// - Low sync bit waits for low carrier falling edge before switching.
// - Low source field in bits 3-0 uses the same encoding.
// - Bits 12 and 4 hold nothing and read as zero.
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
module mcsel_top
  import mcsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Carrier sources
  input wire logic carrier_input_pin_one,
  input wire logic carrier_input_pin_two,
  input wire logic reference_clock_output,
  input wire logic [MCSEL_PWM_COUNT-1:0] pwm_outputs,
  // Modulation data
  input wire logic modulation_data,
  // Modulator outputs
  output logic modulator_out,
  output logic high_carrier_pin_en,
  output logic low_carrier_pin_en
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = MCSEL_PWM_COUNT + 4;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {modulation_data, pwm_outputs, reference_clock_output,
                    carrier_input_pin_two, carrier_input_pin_one};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] ctrl_reg;
  logic [1:0] data_ctrl_reg;
  logic wb_req;
  logic wr_ctrl;
  logic wr_data;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = wb_req && wb_we_i && (wb_adr_i == MCSEL_CARRIER_CTRL_ADDR);
  assign wr_data = wb_req && wb_we_i && (wb_adr_i == MCSEL_DATA_CTRL_ADDR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= MCSEL_CTRL_RESET;
    end else if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        ctrl_reg[7:0] <= wb_dat_i[7:0] & MCSEL_CTRL_MASK[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_reg[15:8] <= wb_dat_i[15:8] & MCSEL_CTRL_MASK[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ctrl_reg <= MCSEL_DATA_RESET;
    end else if (wr_data && wb_sel_i[0]) begin
      data_ctrl_reg <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------
  // Carrier selection
  // ----------------------------------------
  function automatic logic pick_src(input logic [3:0] code, input logic [NSYNC-1:0] s);
    logic r;
    r = 1'b0;
    case (code)
      MCSEL_SRC_GROUND: r = 1'b0;
      MCSEL_SRC_PIN_ONE: r = s[0];
      MCSEL_SRC_PIN_TWO: r = s[1];
      MCSEL_SRC_REFCLK: r = s[2];
      default: begin
        if (code >= MCSEL_SRC_PWM_FIRST && code <= MCSEL_SRC_PWM_LAST) begin
          r = s[3 + 32'(code - MCSEL_SRC_PWM_FIRST)];
        end else begin
          r = 1'b0;
        end
      end
    endcase
    return r;
  endfunction

  logic hi_carrier;
  logic lo_carrier;
  logic data_now;
  assign hi_carrier = pick_src(ctrl_reg[MCSEL_HI_SRC_LSB +: 4], sync2_reg)
                      ^ ctrl_reg[MCSEL_HI_INV_BIT];
  assign lo_carrier = pick_src(ctrl_reg[MCSEL_LO_SRC_LSB +: 4], sync2_reg)
                      ^ ctrl_reg[MCSEL_LO_INV_BIT];
  assign data_now = data_ctrl_reg[MCSEL_DATA_SEL_BIT] ? data_ctrl_reg[MCSEL_DATA_SW_BIT]
                                                        : sync2_reg[NSYNC-1];

  // ----------------------------------------
  // Falling edge detect
  // ----------------------------------------
  logic hi_prev_reg;
  logic lo_prev_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_prev_reg <= 1'b0;
      lo_prev_reg <= 1'b0;
    end else begin
      hi_prev_reg <= hi_carrier;
      lo_prev_reg <= lo_carrier;
    end
  end
  logic hi_fall;
  logic lo_fall;
  assign hi_fall = hi_prev_reg && !hi_carrier;
  assign lo_fall = lo_prev_reg && !lo_carrier;

  // ----------------------------------------
  // Carrier switching
  // ----------------------------------------
  mcsel_state_t state_reg;
  mcsel_state_t state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MCSEL_ON_LOW: begin
        if (data_now) begin
          if (ctrl_reg[MCSEL_LO_SYNC_BIT] && !lo_fall) begin
            state_next = MCSEL_WAIT_LO_FALL;
          end else begin
            state_next = MCSEL_ON_HIGH;
          end
        end
      end
      MCSEL_ON_HIGH: begin
        if (!data_now) begin
          if (ctrl_reg[MCSEL_HI_SYNC_BIT] && !hi_fall) begin
            state_next = MCSEL_WAIT_HI_FALL;
          end else begin
            state_next = MCSEL_ON_LOW;
          end
        end
      end
      MCSEL_WAIT_HI_FALL: begin
        if (data_now) begin
          state_next = MCSEL_ON_HIGH;
        end else if (hi_fall || !ctrl_reg[MCSEL_HI_SYNC_BIT]) begin
          state_next = MCSEL_ON_LOW;
        end
      end
      MCSEL_WAIT_LO_FALL: begin
        if (!data_now) begin
          state_next = MCSEL_ON_LOW;
        end else if (lo_fall || !ctrl_reg[MCSEL_LO_SYNC_BIT]) begin
          state_next = MCSEL_ON_HIGH;
        end
      end
      default: state_next = MCSEL_ON_LOW;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= MCSEL_ON_LOW;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic use_high;
  assign use_high = (state_next == MCSEL_ON_HIGH) || (state_next == MCSEL_WAIT_HI_FALL);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modulator_out <= 1'b0;
      high_carrier_pin_en <= 1'b0;
      low_carrier_pin_en <= 1'b0;
    end else begin
      modulator_out <= use_high ? hi_carrier : lo_carrier;
      high_carrier_pin_en <= !ctrl_reg[MCSEL_HI_DIS_BIT];
      low_carrier_pin_en <= !ctrl_reg[MCSEL_LO_DIS_BIT];
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          MCSEL_CARRIER_CTRL_ADDR: wb_dat_o <= {16'h0000, ctrl_reg};
          MCSEL_DATA_CTRL_ADDR: wb_dat_o <= {30'h0000_0000, data_ctrl_reg};
          MCSEL_STATUS_ADDR: wb_dat_o <= {29'h0000_0000, use_high, state_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// *** rtl/mcsel_pkg.sv ***
// Constants for the modulator carrier select block.
// Assumes a 32-bit classic Wishbone register bus.
package mcsel_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] MCSEL_CARRIER_CTRL_ADDR = 8'h00;
  localparam logic [7:0] MCSEL_DATA_CTRL_ADDR = 8'h04;
  localparam logic [7:0] MCSEL_STATUS_ADDR = 8'h08;
  // ----------------------------------------
  // Carrier control fields
  // ----------------------------------------
  localparam int MCSEL_HI_DIS_BIT = 15;
  localparam int MCSEL_HI_INV_BIT = 14;
  localparam int MCSEL_HI_SYNC_BIT = 13;
  localparam int MCSEL_HI_SRC_LSB = 8;
  localparam int MCSEL_LO_DIS_BIT = 7;
  localparam int MCSEL_LO_INV_BIT = 6;
  localparam int MCSEL_LO_SYNC_BIT = 5;
  localparam int MCSEL_LO_SRC_LSB = 0;
  localparam logic [15:0] MCSEL_CTRL_MASK = 16'hEFEF;
  localparam logic [15:0] MCSEL_CTRL_RESET = 16'h0000;
  // ----------------------------------------
  // Data control fields
  // ----------------------------------------
  localparam int MCSEL_DATA_SW_BIT = 0;
  localparam int MCSEL_DATA_SEL_BIT = 1;
  localparam logic [1:0] MCSEL_DATA_RESET = 2'h0;
  // ----------------------------------------
  // Carrier source codes
  // ----------------------------------------
  localparam logic [3:0] MCSEL_SRC_GROUND = 4'h0;
  localparam logic [3:0] MCSEL_SRC_PIN_ONE = 4'h1;
  localparam logic [3:0] MCSEL_SRC_PIN_TWO = 4'h2;
  localparam logic [3:0] MCSEL_SRC_REFCLK = 4'h3;
  localparam logic [3:0] MCSEL_SRC_PWM_FIRST = 4'h4;
  localparam logic [3:0] MCSEL_SRC_PWM_LAST = 4'hA;
  localparam int MCSEL_PWM_COUNT = 7;
  // ----------------------------------------
  // Output stage states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MCSEL_ON_LOW = 2'b00,
    MCSEL_ON_HIGH = 2'b01,
    MCSEL_WAIT_HI_FALL = 2'b11,
    MCSEL_WAIT_LO_FALL = 2'b10
  } mcsel_state_t;
endpackage

// *** tb/mcsel_carrier_model.sv ***
// Carrier source model: input pins, reference clock, PWM outputs.
// Assumes the bench picks each source level through lvl.
`timescale 1ns/1ps
module mcsel_carrier_model (
  // Clock and levels
  input wire logic clk,
  input wire logic [9:0] lvl,
  // Carrier sources
  output logic pin_one,
  output logic pin_two,
  output logic ref_clk,
  output logic [6:0] pwm
);
  // ----------------------------------------
  // Sources, launched on the clock
  // ----------------------------------------
  always_ff @(posedge clk) begin
    {pwm, ref_clk, pin_two, pin_one} <= lvl;
  end
endmodule

// *** tb/mcsel_top_properties.sv ***
// Port checker for mcsel_top.
// Assumes bus writes use all byte lanes; shadows the control register.
`timescale 1ns/1ps
module mcsel_top_properties
  import mcsel_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Outputs
  input wire logic modulator_out,
  input wire logic high_carrier_pin_en,
  input wire logic low_carrier_pin_en
);
  // ----------------------------------------
  // Shadow of control and its age
  // ----------------------------------------
  logic [15:0] sh_reg;
  logic [2:0] age_reg;
  logic take, rd0, dead_hi, dead_lo;
  logic live_reg;
  // Set one edge after reset, so pin enables have left reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
    end
  end
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00;
  assign rd0 = wb_ack_o && !wb_we_i && wb_adr_i == MCSEL_CARRIER_CTRL_ADDR;
  assign dead_hi = sh_reg[11:8] == MCSEL_SRC_GROUND || sh_reg[11:8] > MCSEL_SRC_PWM_LAST;
  assign dead_lo = sh_reg[3:0] == MCSEL_SRC_GROUND || sh_reg[3:0] > MCSEL_SRC_PWM_LAST;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_reg <= MCSEL_CTRL_RESET;
      age_reg <= 3'h0;
    end else if (take) begin
      sh_reg <= wb_dat_i[15:0] & MCSEL_CTRL_MASK;
      age_reg <= 3'h0;
    end else if (age_reg != 3'h7) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  a_ack_answer: assert property (@(posedge clk) disable iff (!reset_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ctrl_readback: assert property (@(posedge clk) disable iff (!reset_n)
    rd0 |-> wb_dat_o == {16'h0000, sh_reg}) else $error("ctrl read wrong");
  a_unused_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rd0 |-> !wb_dat_o[12] && !wb_dat_o[4]) else $error("unused bit set");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o && !wb_we_i && wb_adr_i > 8'h08 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read");
  a_hi_pin_en: assert property (@(posedge clk) disable iff (!reset_n)
    live_reg |-> high_carrier_pin_en == !$past(sh_reg[15])) else $error("hi pin en");
  a_lo_pin_en: assert property (@(posedge clk) disable iff (!reset_n)
    live_reg |-> low_carrier_pin_en == !$past(sh_reg[7])) else $error("lo pin en");
  a_const_out: assert property (@(posedge clk) disable iff (!reset_n)
    age_reg == 3'h7 && dead_hi && dead_lo && sh_reg[14] == sh_reg[6] && !sh_reg[13]
    && !sh_reg[5] |-> modulator_out == sh_reg[14]) else $error("const out wrong");
endmodule
bind mcsel_top mcsel_top_properties u_mcsel_top_properties (.clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .modulator_out,
  .high_carrier_pin_en, .low_carrier_pin_en);

// *** tb/mcsel_top_test.sv ***
// Self-checking bench for mcsel_top.
// Assumes carrier sources come from the carrier model.
`timescale 1ns/1ps
module mcsel_top_test;
  import mcsel_pkg::*;
  logic clk = 0, reset_n = 0, cyc = 0, we = 0, mdata = 0, p1, p2, rf, hen, len, mout, ack;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, rdat;
  logic [9:0] lvl = 0;
  logic [6:0] pwm;
  int err_count = 0, num_checks = 0;
  always #4 clk = ~clk;
  mcsel_carrier_model u_mcsel_carrier_model (.clk, .lvl, .pin_one(p1), .pin_two(p2),
    .ref_clk(rf), .pwm);
  mcsel_top u_mcsel_top (.clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .carrier_input_pin_one(p1), .carrier_input_pin_two(p2), .reference_clock_output(rf),
    .pwm_outputs(pwm), .modulation_data(mdata), .modulator_out(mout),
    .high_carrier_pin_en(hen), .low_carrier_pin_en(len));
  // ----------------------------------------
  // Bus, compare and settle tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    {cyc, we, adr, dat} <= {1'b1, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
  endtask
  task automatic settle(input logic [9:0] l, input logic m);
    lvl <= l;
    mdata <= m;
    repeat (8) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    xfer(0, MCSEL_CARRIER_CTRL_ADDR, 0, d);
    chk("ctrl reset", 0, d);
    chk("pins on", 2'b11, {hen, len});
    xfer(1, MCSEL_CARRIER_CTRL_ADDR, 32'hFFFF_FFFF, d);
    xfer(0, MCSEL_CARRIER_CTRL_ADDR, 0, d);
    chk("ctrl mask", 32'h0000_EFEF, d);
    chk("pins off", 2'b00, {hen, len});
    xfer(0, 8'h40, 0, d);
    chk("unmapped", 0, d);
  endtask
  task automatic t_decode(input bit lo);
    logic [31:0] d;
    logic [15:0] c;
    logic [9:0] oh;
    for (int k = 0; k < 64; k++) begin
      c = 16'(k / 4) | (k[0] ? 16'h0040 : 16'h0000);
      oh = (c[3:0] >= 1 && c[3:0] <= 10) ? 10'h001 << (c[3:0] - 1) : 10'h000;
      xfer(1, MCSEL_CARRIER_CTRL_ADDR, lo ? c : c << 8, d);
      settle(k[1] ? ~oh : oh, !lo);
      chk("decode", (oh != 0 && !k[1]) ^ k[0], mout);
    end
  endtask
  task automatic t_sync(input bit lo);
    logic [31:0] d;
    // Sync on the carrier being left
    xfer(1, MCSEL_CARRIER_CTRL_ADDR, lo ? 16'h0122 : 16'h2102, d);
    settle(lo ? 10'h002 : 10'h001, lo ? 0 : 1);
    chk("follow", 1, mout);
    settle(lo ? 10'h002 : 10'h001, lo ? 1 : 0);
    chk("hold", 1, mout);
    settle(lo ? 10'h001 : 10'h002, lo ? 1 : 0);
    chk("switched", 1, mout);
    xfer(1, MCSEL_CARRIER_CTRL_ADDR, 16'h0102, d);
    settle(lo ? 10'h002 : 10'h001, lo ? 0 : 1);
    settle(lo ? 10'h002 : 10'h001, lo ? 1 : 0);
    chk("no sync", 0, mout);
  endtask
  task automatic t_soft();
    logic [31:0] d;
    xfer(1, MCSEL_CARRIER_CTRL_ADDR, 32'h0000_0102, d);
    xfer(1, MCSEL_DATA_CTRL_ADDR, 32'h0000_0003, d);
    settle(10'h001, 0);
    chk("soft high", 1, mout);
    xfer(0, MCSEL_STATUS_ADDR, 0, d);
    chk("status high", 32'h0000_0005, d);
    xfer(0, MCSEL_DATA_CTRL_ADDR, 0, d);
    chk("data ctrl", 32'h0000_0003, d);
    xfer(1, MCSEL_DATA_CTRL_ADDR, 32'h0000_0002, d);
    settle(10'h002, 1);
    chk("soft low", 1, mout);
    xfer(0, MCSEL_STATUS_ADDR, 0, d);
    chk("status low", 32'h0000_0000, d);
    xfer(1, MCSEL_DATA_CTRL_ADDR, 32'h0000_0000, d);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_decode(0);
    t_decode(1);
    t_sync(0);
    t_sync(1);
    t_soft();
    tally_and_finish();
  end
endmodule
